// ---- design/patd_defines.vh ----
// constants for the pwm active tamper detector
`ifndef PATD_DEFINES_VH
`define PATD_DEFINES_VH

// slow clock nominal rate in Hz and system clock rate in Hz
`define PATD_SLOW_HZ 32768
`define PATD_MCLK_HZ 40000000
// system clocks per slow-clock edge (rounded down)
`define PATD_SLOW_DIV (`PATD_MCLK_HZ / `PATD_SLOW_HZ)
// counter width for the divider
`define PATD_DIV_W 11
// last divider count of a slow period, and mid-period sample point
`define PATD_DIV_LAST 11'h4C3
`define PATD_SAMPLE_AT 11'h261
// number of independent detector instances (two per port, two ports)
`define PATD_NUM 4
// reset values: toggle low, previous sample holds match
`define PATD_DRIVE_RST 1'b0
`define PATD_PREV_RST 1'b1
`define PATD_OK_RST 1'b1
`define PATD_SENSE_RST 1'b0

`endif

// ---- design/patd_top.v ----
// active tamper detector: square-wave drive, sense compare, ok status
// How it works
// - drive output toggles every slow clock edge
// - drive and stored sample advance only on slow clock enables
// - xnor compares drive against sense
// - each slow edge stores equivalence result
// - ok equals live result or stored sample
// - ok low only after two mismatches
// - one sample clocked, one evaluated live
// - detection within about two slow cycles
// - ok falling edge usable as wake
// - three pins per instance, four instances
`include "patd_defines.vh"
`default_nettype none

module patd_top (
  // clock and reset
  input wire I_MCLK,
  input wire I_RST_N,
  // loop sense inputs, one per instance
  input wire [`PATD_NUM-1:0] I_SENSE,
  // loop drive outputs
  output reg [`PATD_NUM-1:0] O_DRIVE,
  // ok status, active high, one per instance
  output reg [`PATD_NUM-1:0] O_OK,
  // one-cycle pulse on a falling ok (wake request)
  output reg O_WAKE
);

  // half-period phase codes
  localparam PH_LEAD = 2'b01;
  localparam PH_TRAIL = 2'b10;

  // divider state
  reg [`PATD_DIV_W-1:0] div_cnt;
  reg [`PATD_DIV_W-1:0] next_div_cnt;
  reg [1:0] phase;
  reg [1:0] next_phase;
  // slow rate enables: drive toggle and mid-period sample
  reg toggle_en;
  reg sample_en;
  reg next_toggle_en;
  reg next_sample_en;
  // sense synchroniser stages
  reg [`PATD_NUM-1:0] sense_meta;
  reg [`PATD_NUM-1:0] sense_sync;
  // stored comparison sample per instance
  reg [`PATD_NUM-1:0] prev_eq;
  // live comparison and next status per instance
  wire [`PATD_NUM-1:0] live_eq;
  wire [`PATD_NUM-1:0] next_ok;
  // status falls, one bit per instance
  wire [`PATD_NUM-1:0] ok_fall;
  wire next_wake;

  // equivalence of drive and sense levels
  function eq_bit;
    input drv;
    input sns;
    begin
      eq_bit = ~(drv ^ sns);
    end
  endfunction

  // divider count compare
  function at_count;
    input [`PATD_DIV_W-1:0] cnt;
    input [`PATD_DIV_W-1:0] val;
    begin
      at_count = (cnt == val);
    end
  endfunction

  // slow period counter
  always @* begin
    if (at_count(div_cnt, `PATD_DIV_LAST)) begin
      next_div_cnt = {`PATD_DIV_W{1'b0}};
    end else begin
      next_div_cnt = div_cnt + 1'b1;
    end
  end

  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      div_cnt <= {`PATD_DIV_W{1'b0}};
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // half-period phase tracker
  always @* begin
    case (phase)
      PH_LEAD: begin
        if (at_count(div_cnt, `PATD_SAMPLE_AT)) begin
          next_phase = PH_TRAIL;
        end else begin
          next_phase = PH_LEAD;
        end
      end
      PH_TRAIL: begin
        if (at_count(div_cnt, `PATD_DIV_LAST)) begin
          next_phase = PH_LEAD;
        end else begin
          next_phase = PH_TRAIL;
        end
      end
      default: begin
        next_phase = PH_LEAD;
      end
    endcase
  end

  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      phase <= PH_LEAD;
    end else begin
      phase <= next_phase;
    end
  end

  // sampling sits half a period from the toggle so that both
  // mismatch samples see the same drive level
  always @* begin
    next_toggle_en = 1'b0;
    next_sample_en = 1'b0;
    case (phase)
      PH_LEAD: begin
        next_sample_en = at_count(div_cnt, `PATD_SAMPLE_AT);
      end
      PH_TRAIL: begin
        next_toggle_en = at_count(div_cnt, `PATD_DIV_LAST);
      end
      default: begin
        next_toggle_en = 1'b0;
        next_sample_en = 1'b0;
      end
    endcase
  end

  // one-cycle enables
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      toggle_en <= 1'b0;
      sample_en <= 1'b0;
    end else begin
      toggle_en <= next_toggle_en;
      sample_en <= next_sample_en;
    end
  end

  // two-flop synchroniser on each sense pin
  genvar s;
  generate
    for (s = 0; s < `PATD_NUM; s = s + 1) begin : g_sync
      always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          sense_meta[s] <= `PATD_SENSE_RST;
          sense_sync[s] <= `PATD_SENSE_RST;
        end else begin
          sense_meta[s] <= I_SENSE[s];
          sense_sync[s] <= sense_meta[s];
        end
      end
    end
  endgenerate

  // per-instance detector
  genvar g;
  generate
    for (g = 0; g < `PATD_NUM; g = g + 1) begin : g_det
      // unclocked comparison sample
      assign live_eq[g] = eq_bit(O_DRIVE[g], sense_sync[g]);
      // either sample matching keeps the status high
      assign next_ok[g] = live_eq[g] | prev_eq[g];
      assign ok_fall[g] = O_OK[g] & ~next_ok[g];

      // square-wave drive
      always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          O_DRIVE[g] <= `PATD_DRIVE_RST;
        end else if (toggle_en) begin
          O_DRIVE[g] <= ~O_DRIVE[g];
        end
      end

      // stored sample
      always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          prev_eq[g] <= `PATD_PREV_RST;
        end else if (sample_en) begin
          prev_eq[g] <= live_eq[g];
        end
      end

      // status register
      always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
          O_OK[g] <= `PATD_OK_RST;
        end else begin
          O_OK[g] <= next_ok[g];
        end
      end
    end
  endgenerate

  // any instance falling raises wake
  assign next_wake = |ok_fall;

  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      O_WAKE <= 1'b0;
    end else begin
      O_WAKE <= next_wake;
    end
  end

endmodule

`default_nettype wire

// ---- sim/patd_assertions.sv ----
// port checker for the tamper detector
`default_nettype none
module patd_assertions(input wire logic I_MCLK, input wire logic I_RST_N,
  input wire logic [3:0] I_SENSE, input wire logic [3:0] O_DRIVE,
  input wire logic [3:0] O_OK, input wire logic O_WAKE);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] gap;
  logic seen;
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  property p_wk; O_WAKE == |($past(O_OK) & ~O_OK); endproperty
  a_wk: assert property (p_wk) else $error("wake mismatch");
  property p_dr;
    $changed(O_DRIVE) |-> O_DRIVE == ~$past(O_DRIVE) ##1 $stable(O_DRIVE)[*8];
  endproperty
  a_dr: assert property (p_dr) else $error("drive bad");
  property p_rs;
    disable iff (1'b0) !I_RST_N |=> O_OK == 4'hF && !O_WAKE;
  endproperty
  a_rs: assert property (p_rs) else $error("reset bad");
  // cycles since the last drive change
  always @(posedge I_MCLK) begin
    if (!I_RST_N) begin
      gap <= 11'h000;
      seen <= 1'b0;
    end else if ($changed(O_DRIVE)) begin
      gap <= 11'h000;
      seen <= 1'b1;
    end else if (gap != 11'h7FF) begin
      gap <= gap + 11'h001;
    end
  end
  property p_per; seen && $changed(O_DRIVE) |-> gap == 11'h4C3; endproperty
  a_per: assert property (p_per) else $error("drive period bad");
  property p_same; O_DRIVE == 4'h0 || O_DRIVE == 4'hF; endproperty
  a_same: assert property (p_same) else $error("drives differ");
  property p_fall;
    (($past(O_OK) & ~O_OK) & ~($past(O_DRIVE) ^ $past(I_SENSE, 3))) == 4'h0;
  endproperty
  a_fall: assert property (p_fall) else $error("ok fell on match");
endmodule
bind patd_top patd_assertions chk(.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
  .I_SENSE(I_SENSE), .O_DRIVE(O_DRIVE), .O_OK(O_OK), .O_WAKE(O_WAKE));
`default_nettype wire

// ---- sim/patd_loop.sv ----
// loop wiring: closed switch echoes drive, open line reads pull-up
`default_nettype none
module patd_loop(input wire logic [3:0] drv, input wire logic [3:0] brk,
  output wire logic [3:0] sense);
  timeunit 1ns;
  timeprecision 100ps;
  assign sense = drv | brk;
endmodule
`default_nettype wire

// ---- sim/patd_top_test.sv ----
// self-checking bench for the tamper detector
`default_nettype none
module patd_top_test;
  timeunit 1ns; timeprecision 100ps;
  logic I_MCLK = 0, I_RST_N = 0, O_WAKE;
  logic [3:0] brk = 0, I_SENSE, O_DRIVE, O_OK, q[$];
  int n_mismatch = 0, checked = 0, k, w;
  always #12.5 I_MCLK = ~I_MCLK;
  patd_top uut(.I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_SENSE(I_SENSE),
    .O_DRIVE(O_DRIVE), .O_OK(O_OK), .O_WAKE(O_WAKE));
  patd_loop lp(.drv(O_DRIVE), .brk(brk), .sense(I_SENSE));
  task automatic cmp(input logic [3:0] g, input logic [3:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t ok %h exp %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(negedge I_MCLK) if (O_WAKE === 1'b1) begin
    cmp(O_OK, q.size() ? q.pop_front() : 4'hF);
  end
  initial begin
    k = $urandom(90233);
    repeat (3) @(posedge I_MCLK);
    I_RST_N <= 1;
    repeat (3000) @(posedge I_MCLK);
    cmp(O_OK, 4'hF);
    for (int t = 0; t < 4; t++) begin
      k = $urandom % 4;
      q.push_back(~(4'h1 << k));
      brk <= 4'h1 << k;
      for (w = 0; w < 2500 && O_OK[k] !== 1'b0; w++) @(posedge I_MCLK);
      if (w == 2500) begin
        n_mismatch++;
        complete_run;
      end
      cmp(O_OK, ~(4'h1 << k));
      brk <= 0;
      I_RST_N <= 0;
      repeat (3) @(posedge I_MCLK);
      I_RST_N <= 1;
      @(posedge I_MCLK);
      #1 cmp(O_OK, 4'hF);
      $display("test %0d done", t);
    end
    complete_run;
  end
endmodule
`default_nettype wire
